/* src/rsuc_consts.svh */
`ifndef RSUC_CONSTS_SVH
`define RSUC_CONSTS_SVH

// ----------------------------------------
// Event codes
// ----------------------------------------
`define RSUC_EV_ADDR_RING 8'h3e
`define RSUC_EV_ACK_RING  8'h3f
`define RSUC_EV_DATA_RING 8'h40

// ----------------------------------------
// Ring selection
// ----------------------------------------
`define RSUC_RING_ADDR 2'h0
`define RSUC_RING_ACK  2'h1
`define RSUC_RING_DATA 2'h2

// ----------------------------------------
// Unit-mask bits and patterns
// ----------------------------------------
`define RSUC_UM_CWE_V0   0
`define RSUC_UM_CWE_V1   4
`define RSUC_UM_LO_LSB   0
`define RSUC_UM_LO_MSB   3
`define RSUC_UM_HI_LSB   4
`define RSUC_UM_HI_MSB   7
`define RSUC_UM_ALL_CW   8'h33
`define RSUC_UM_ALL_CCW  8'hcc
`define RSUC_UM_NONE     8'h00

// ----------------------------------------
// Config word layout
// ----------------------------------------
`define RSUC_CFG_CODE_LSB 0
`define RSUC_CFG_CODE_MSB 7
`define RSUC_CFG_UM_LSB   8
`define RSUC_CFG_UM_MSB   15
`define RSUC_CFG_CLR_BIT  17
`define RSUC_CFG_EN_BIT   22
`define RSUC_CFG_TWO_BIT  23
`define RSUC_CFG_RESET    32'h0000_0000

// ----------------------------------------
// Word indices, byte address is four times
// ----------------------------------------
`define RSUC_IDX_CFG  4'h0
`define RSUC_IDX_LO   4'h4
`define RSUC_IDX_HI   4'h8
`define RSUC_IDX_STAT 4'hc
`define RSUC_ADDR_LSB 2
`define RSUC_ADDR_MSB 5

`endif

/* src/rsuc_evt_sel.sv */
`timescale 1ns/1ps
`default_nettype none

module rsuc_evt_sel
    import rsuc_pkg::*;
#(
    parameter int NCNT = 4
) (
    // Config in, increments out
    rsuc_sel_if.sel sif
);

    rsuc_ring_sel_t rs;
    logic [7:0]     occ8;

    always_comb begin
        rs   = '0;
        occ8 = '0;
        for (int n = 0; n < NCNT; n++) begin
            rs   = rsuc_ring_of(sif.cfg[n].code);
            occ8 = sif.occ[rs.ring];
            // Two columns: low mask bits see both virtual rings
            if (sif.cfg[n].two_col) begin
                occ8[`RSUC_UM_LO_MSB:`RSUC_UM_LO_LSB] =
                    occ8[`RSUC_UM_LO_MSB:`RSUC_UM_LO_LSB] |
                    occ8[`RSUC_UM_HI_MSB:`RSUC_UM_HI_LSB];
            end
            // Any selected bit counts the cycle once
            sif.inc[n] = sif.cfg[n].en & rs.vld &
                         (|(sif.cfg[n].umask & occ8));
        end
    end

endmodule : rsuc_evt_sel

`default_nettype wire

/* src/rsuc_pkg.sv */
`include "rsuc_consts.svh"

package rsuc_pkg;

    typedef enum logic {
        RSUC_BUS_IDLE = 1'b0,
        RSUC_BUS_ACK  = 1'b1
    } rsuc_bus_st_t;

    typedef struct packed {
        logic       vld;
        logic [1:0] ring;
    } rsuc_ring_sel_t;

    typedef struct packed {
        logic       two_col;
        logic       en;
        logic [7:0] umask;
        logic [7:0] code;
    } rsuc_cfg_t;

    function automatic rsuc_ring_sel_t rsuc_ring_of(input logic [7:0] code);
        rsuc_ring_sel_t s;
        s = '0;
        case (code)
            `RSUC_EV_ADDR_RING: s = '{1'b1, `RSUC_RING_ADDR};
            `RSUC_EV_ACK_RING:  s = '{1'b1, `RSUC_RING_ACK};
            `RSUC_EV_DATA_RING: s = '{1'b1, `RSUC_RING_DATA};
            default:            s = '0;
        endcase
        return s;
    endfunction : rsuc_ring_of

endpackage : rsuc_pkg

/* src/rsuc_sel_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface rsuc_sel_if
    import rsuc_pkg::*;
#(
    parameter int NCNT = 4
);
    rsuc_cfg_t [NCNT-1:0] cfg;
    logic [2:0][7:0]      occ;
    logic [NCNT-1:0]      inc;

    modport ctl (output cfg, output occ, input inc);
    modport sel (input cfg, input occ, output inc);
endinterface : rsuc_sel_if

`default_nettype wire

/* src/rsuc_top.sv */
// How it works
// - Code 0x3e counts each cycle the address ring is occupied here.
// - Code 0x3f counts each cycle the acknowledge ring is occupied here.
// - Code 0x40 counts each cycle the data-block ring is occupied here.
// - Passing and sunk packets count; packets injected by this stop do not.
// - At most one per cycle; only counters 0 to 3 exist.
// - Mask bit 0 clockwise even vring 0; bit 1 clockwise odd vring 0.
// - Mask bit 2 counterclockwise even vring 0; bit 3 counterclockwise odd.
// - Mask bit 4 clockwise even vring 1; bit 5 clockwise odd vring 1.
// - Mask bit 6 counterclockwise even vring 1; bit 7 counterclockwise odd.
// - Mask 0x33 counts any clockwise occupancy.
// - Mask 0xcc counts any counterclockwise occupancy.
// - Per ring, at most one clockwise and one counterclockwise packet a cycle.
// - Two-column mode: vring0 selection covers vring0 plus vring1.
`timescale 1ns/1ps
`default_nettype none
`include "rsuc_consts.svh"

module rsuc_top
    import rsuc_pkg::*;
#(
    parameter int NCNT  = 4,
    parameter int CNT_W = 48
) (
    // Clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    // Avalon-MM slave
    input  wire logic [5:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    // Ring observation, [ring][slot]
    input  wire logic [2:0][7:0]       ring_slot_vld_i,
    input  wire logic [2:0][7:0]       ring_slot_inj_i
);

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    // Only four general counters can carry these events
    if (NCNT < 1 || NCNT > 4) begin : g_bad_ncnt
        $error("NCNT must be 1 to 4");
    end
    if (CNT_W < 33 || CNT_W > 64) begin : g_bad_cnt_w
        $error("CNT_W must be 33 to 64");
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return r;
    endfunction : be_merge

    function automatic logic [31:0] cfg_word(input rsuc_cfg_t c);
        logic [31:0] w;
        w = `RSUC_CFG_RESET;
        w[`RSUC_CFG_CODE_MSB:`RSUC_CFG_CODE_LSB] = c.code;
        w[`RSUC_CFG_UM_MSB:`RSUC_CFG_UM_LSB]     = c.umask;
        w[`RSUC_CFG_EN_BIT]                      = c.en;
        w[`RSUC_CFG_TWO_BIT]                     = c.two_col;
        return w;
    endfunction : cfg_word

    // ----------------------------------------
    // State
    // ----------------------------------------
    rsuc_bus_st_t              st_ff, nxt_st;
    logic [31:0]               rdata_ff, nxt_rdata;
    rsuc_cfg_t [NCNT-1:0]      cfg_ff, nxt_cfg;
    logic [NCNT-1:0][CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [3:0]                word;
    logic                      req;
    logic                      wr_go;
    logic [31:0]               wmerged;
    logic [NCNT-1:0]           code_ok;

    rsuc_sel_if #(.NCNT(NCNT)) sif ();

    // ----------------------------------------
    // Event selection
    // ----------------------------------------
    assign sif.cfg = cfg_ff;
    // Injected slots are masked out before selection
    assign sif.occ = ring_slot_vld_i & ~ring_slot_inj_i;

    rsuc_evt_sel #(.NCNT(NCNT)) u_sel (
        .sif (sif.sel)
    );

    rsuc_ring_sel_t [NCNT-1:0] rsel;
    logic [7:0]                occ_sel0;

    always_comb begin
        for (int n = 0; n < NCNT; n++) begin
            rsel[n]    = rsuc_ring_of(cfg_ff[n].code);
            code_ok[n] = rsel[n].vld;
        end
    end
    // Counter 0's selected ring, for the checks below
    assign occ_sel0 = sif.occ[rsel[0].ring];

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // One wait cycle gives the read mux a full cycle to settle
    assign req             = avs_read | avs_write;
    assign word            = avs_address[`RSUC_ADDR_MSB:`RSUC_ADDR_LSB];
    assign avs_waitrequest = req & (st_ff != RSUC_BUS_ACK);
    assign wr_go           = avs_write & (st_ff == RSUC_BUS_ACK);
    assign avs_readdata    = rdata_ff;

    always_comb begin
        nxt_st    = st_ff;
        nxt_rdata = rdata_ff;
        unique case (st_ff)
            RSUC_BUS_IDLE: begin
                if (req) nxt_st = RSUC_BUS_ACK;
            end
            RSUC_BUS_ACK: begin
                nxt_st = RSUC_BUS_IDLE;
            end
        endcase
        // Snapshot taken one cycle before the answer; low and high
        // halves are separate reads and can tear while counting
        if (st_ff == RSUC_BUS_IDLE && avs_read) begin
            nxt_rdata = '0;
            for (int n = 0; n < NCNT; n++) begin
                if (word == `RSUC_IDX_CFG + 4'(n)) nxt_rdata = cfg_word(cfg_ff[n]);
                if (word == `RSUC_IDX_LO + 4'(n))  nxt_rdata = cnt_ff[n][31:0];
                if (word == `RSUC_IDX_HI + 4'(n)) begin
                    nxt_rdata = 32'(cnt_ff[n][CNT_W-1:32]);
                end
            end
            if (word == `RSUC_IDX_STAT) begin
                nxt_rdata = {24'h00_0000, 4'(code_ok), 4'(sif.inc)};
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_ff    <= RSUC_BUS_IDLE;
            rdata_ff <= 32'h0000_0000;
        end else begin
            st_ff    <= nxt_st;
            rdata_ff <= nxt_rdata;
        end
    end

    // ----------------------------------------
    // Config and counters
    // ----------------------------------------
    always_comb begin
        wmerged = be_merge(`RSUC_CFG_RESET, avs_writedata, avs_byteenable);
        nxt_cfg = cfg_ff;
        nxt_cnt = cnt_ff;
        for (int n = 0; n < NCNT; n++) begin
            // Increment gated by enable and a ring code
            nxt_cnt[n] = cnt_ff[n] + CNT_W'(sif.inc[n]);
            if (wr_go && word == `RSUC_IDX_CFG + 4'(n)) begin
                wmerged = be_merge(cfg_word(cfg_ff[n]), avs_writedata, avs_byteenable);
                nxt_cfg[n].code    = wmerged[`RSUC_CFG_CODE_MSB:`RSUC_CFG_CODE_LSB];
                nxt_cfg[n].umask   = wmerged[`RSUC_CFG_UM_MSB:`RSUC_CFG_UM_LSB];
                nxt_cfg[n].en      = wmerged[`RSUC_CFG_EN_BIT];
                nxt_cfg[n].two_col = wmerged[`RSUC_CFG_TWO_BIT];
                // Clear request wins over a same-cycle event
                if (wmerged[`RSUC_CFG_CLR_BIT]) nxt_cnt[n] = '0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cfg_ff <= '0;
            cnt_ff <= '0;
        end else begin
            cfg_ff <= nxt_cfg;
            cnt_ff <= nxt_cnt;
        end
    end

    // ----------------------------------------
    // Checks on counter 0, the bus handshake and read data
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    logic [7:0] occ_addr, occ_ack, occ_data;
    assign occ_addr = ring_slot_vld_i[`RSUC_RING_ADDR] & ~ring_slot_inj_i[`RSUC_RING_ADDR];
    assign occ_ack  = ring_slot_vld_i[`RSUC_RING_ACK] & ~ring_slot_inj_i[`RSUC_RING_ACK];
    assign occ_data = ring_slot_vld_i[`RSUC_RING_DATA] & ~ring_slot_inj_i[`RSUC_RING_DATA];

    a_addr_count: assert property (
        (cfg_ff[0].en && cfg_ff[0].code == `RSUC_EV_ADDR_RING
         && |(cfg_ff[0].umask & occ_addr) && !wr_go)
        |=> cnt_ff[0] == $past(cnt_ff[0]) + 1'b1)
        else $error("address ring occupancy not counted");

    a_ack_count: assert property (
        (cfg_ff[0].en && cfg_ff[0].code == `RSUC_EV_ACK_RING
         && |(cfg_ff[0].umask & occ_ack) && !wr_go)
        |=> cnt_ff[0] == $past(cnt_ff[0]) + 1'b1)
        else $error("ack ring occupancy not counted");

    a_data_count: assert property (
        (cfg_ff[0].en && cfg_ff[0].code == `RSUC_EV_DATA_RING
         && |(cfg_ff[0].umask & occ_data) && !wr_go)
        |=> cnt_ff[0] == $past(cnt_ff[0]) + 1'b1)
        else $error("data ring occupancy not counted");

    a_inject_skip: assert property (
        (cfg_ff[0].code == `RSUC_EV_ADDR_RING
         && ring_slot_vld_i[`RSUC_RING_ADDR] == ring_slot_inj_i[`RSUC_RING_ADDR] && !wr_go)
        |=> $stable(cnt_ff[0]))
        else $error("injected packet counted");

    a_inc_max_one: assert property (
        !wr_go |=> (cnt_ff[0] - $past(cnt_ff[0])) <= CNT_W'(1))
        else $error("counter stepped by more than one");

    a_mask_select: assert property (
        (!cfg_ff[0].two_col && cfg_ff[0].en && code_ok[0]
         && (cfg_ff[0].umask & occ_sel0) == `RSUC_UM_NONE)
        |-> !sif.inc[0])
        else $error("unselected slot counted");

    a_all_cw: assert property (
        (cfg_ff[0].en && code_ok[0] && cfg_ff[0].umask == `RSUC_UM_ALL_CW
         && |(occ_sel0 & `RSUC_UM_ALL_CW))
        |-> sif.inc[0])
        else $error("clockwise occupancy missed");

    a_all_ccw: assert property (
        (cfg_ff[0].en && code_ok[0] && cfg_ff[0].umask == `RSUC_UM_ALL_CCW
         && |(occ_sel0 & `RSUC_UM_ALL_CCW))
        |-> sif.inc[0])
        else $error("counterclockwise occupancy missed");

    a_two_col: assert property (
        (cfg_ff[0].en && cfg_ff[0].two_col && code_ok[0]
         && cfg_ff[0].umask[`RSUC_UM_CWE_V0] && occ_sel0[`RSUC_UM_CWE_V1])
        |-> sif.inc[0])
        else $error("two-column fold missing");

    a_off_hold: assert property (
        (!(cfg_ff[0].en && code_ok[0]) && !wr_go) |=> $stable(cnt_ff[0]))
        else $error("counter moved while disabled");

    a_bus_answer: assert property (
        (req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus answer late");

    a_bus_wait_first: assert property (
        (req && st_ff == RSUC_BUS_IDLE) |-> avs_waitrequest)
        else $error("first bus cycle not held");

    a_clear_wins: assert property (
        (wr_go && word == `RSUC_IDX_CFG && wmerged[`RSUC_CFG_CLR_BIT])
        |=> cnt_ff[0] == '0)
        else $error("clear lost to increment");

    a_cfg_code_write: assert property (
        (wr_go && word == `RSUC_IDX_CFG && avs_byteenable[0])
        |=> cfg_ff[0].code == $past(avs_writedata[`RSUC_CFG_CODE_MSB:`RSUC_CFG_CODE_LSB]))
        else $error("event code not written");

    a_rdata_hold: assert property (
        !(st_ff == RSUC_BUS_IDLE && avs_read) |=> $stable(avs_readdata))
        else $error("read data moved between reads");

    a_low_word: assert property (
        (st_ff == RSUC_BUS_IDLE && avs_read && word == `RSUC_IDX_LO)
        |=> avs_readdata == $past(cnt_ff[0][31:0]))
        else $error("counter low word wrong");

    a_unmapped_zero: assert property (
        (st_ff == RSUC_BUS_IDLE && avs_read && word > `RSUC_IDX_STAT)
        |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped word not zero");

    c_count_run:  cover property (sif.inc[0] ##1 sif.inc[0]);
    c_two_col:    cover property (cfg_ff[0].two_col && sif.inc[0]);
    c_cfg_write:  cover property (wr_go && word == `RSUC_IDX_CFG);
    c_read_count: cover property (avs_read && !avs_waitrequest && word == `RSUC_IDX_LO);
    c_injected:   cover property (cfg_ff[0].en && ring_slot_inj_i[`RSUC_RING_ADDR] != 8'h00);

endmodule : rsuc_top

`default_nettype wire

/* tb/ring_stop_usage_event_counter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rsuc_consts.svh"

module ring_stop_usage_event_counter_tb;
    logic            core_clk_i = 1'b0;
    logic            rst_n_i = 1'b0;
    logic [5:0]      avs_address = 6'h00;
    logic            avs_read = 1'b0;
    logic            avs_write = 1'b0;
    logic [31:0]     avs_writedata = 32'h0;
    logic [31:0]     avs_readdata;
    logic            avs_waitrequest;
    logic            go = 1'b0;
    logic [2:0][7:0] vreq = '0;
    logic [2:0][7:0] ireq = '0;
    logic [2:0][7:0] vld;
    logic [2:0][7:0] inj;
    int              bad_count = 0;
    int              num_checks = 0;

    rsuc_top dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ring_slot_vld_i(vld), .ring_slot_inj_i(inj));
    rsuc_ring_model ring (.core_clk_i(core_clk_i), .go_i(go), .vld_req_i(vreq),
        .inj_req_i(ireq), .vld_o(vld), .inj_o(inj));

    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask : chk

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge core_clk_i);
        avs_read      <= ~wr;
        avs_write     <= wr;
        avs_address   <= a;
        avs_writedata <= d;
        do @(posedge core_clk_i); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic cfg(input int n, input logic [7:0] code, input logic [7:0] mask,
                       input logic en, input logic two);
        logic [31:0] q;
        bus(1'b1, 6'(n * 4), {8'h00, two, en, 4'h0, 1'b1, 1'b0, mask, code}, q);
    endtask : cfg

    task automatic cnt(input int n, input logic [31:0] exp, input string name);
        logic [31:0] q;
        bus(1'b0, 6'((4 + n) * 4), 32'h0, q);
        chk(name, exp, q);
    endtask : cnt

    task automatic drive(input logic [2:0][7:0] v, input logic [2:0][7:0] i, input int n);
        @(posedge core_clk_i);
        go   <= 1'b1;
        vreq <= v;
        ireq <= i;
        repeat (n) @(posedge core_clk_i);
        go <= 1'b0;
        repeat (3) @(posedge core_clk_i);
    endtask : drive

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [31:0] q;
        bus(1'b0, 6'h00, 32'h0, q);
        chk("cfg0 reset", `RSUC_CFG_RESET, q);
        cnt(0, 32'h0, "cnt0 reset");
        bus(1'b1, 6'h10, 32'h1234_5678, q);
        cnt(0, 32'h0, "cnt0 read only");
        bus(1'b0, 6'h34, 32'h0, q);
        chk("unmapped", 32'h0, q);
        bus(1'b0, 6'h20, 32'h0, q);
        chk("cnt0 high", 32'h0, q);
    endtask : t_reset

    // Each ring code counts its own ring only
    task automatic t_codes;
        cfg(0, `RSUC_EV_ADDR_RING, 8'hff, 1'b1, 1'b0);
        cfg(1, `RSUC_EV_ACK_RING, 8'hff, 1'b1, 1'b0);
        cfg(2, `RSUC_EV_DATA_RING, 8'hff, 1'b1, 1'b0);
        cfg(3, `RSUC_EV_DATA_RING, 8'h33, 1'b1, 1'b0);
        drive({8'h00, 8'h00, 8'h01}, '0, 3);
        drive({8'h00, 8'h04, 8'h00}, '0, 4);
        drive({8'h05, 8'h00, 8'h00}, '0, 5);
        cnt(0, 32'd3, "addr ring");
        cnt(1, 32'd4, "ack ring");
        cnt(2, 32'd5, "data ring cw ccw");
        cnt(3, 32'd5, "data ring cnt3");
    endtask : t_codes

    // One mask bit at a time against every slot, plus an injected packet
    task automatic t_mask_bits;
        for (int k = 0; k < 8; k++) begin
            cfg(0, `RSUC_EV_ADDR_RING, 8'(1 << k), 1'b1, 1'b0);
            for (int j = 0; j < 8; j++) drive({8'h00, 8'h00, 8'(1 << j)}, '0, 1);
            drive({8'h00, 8'(1 << k), 8'(1 << k)}, {8'h00, 8'h00, 8'(1 << k)}, 1);
            cnt(0, 32'd1, "mask bit");
        end
    endtask : t_mask_bits

    // Direction patterns see every slot once
    task automatic t_dir;
        for (int p = 0; p < 2; p++) begin
            cfg(p, `RSUC_EV_ACK_RING, `RSUC_UM_ALL_CW, 1'b1, 1'b0);
            cfg(1 - p, `RSUC_EV_ACK_RING, `RSUC_UM_ALL_CCW, 1'b1, 1'b0);
            for (int j = 0; j < 8; j++) drive({8'h00, 8'(1 << j), 8'h00}, '0, 1);
            cnt(p, 32'd4, "all cw");
            cnt(1 - p, 32'd4, "all ccw");
        end
    endtask : t_dir

    task automatic t_two_col;
        logic [31:0] q;
        cfg(0, `RSUC_EV_DATA_RING, 8'h01, 1'b1, 1'b1);
        cfg(1, `RSUC_EV_DATA_RING, 8'h08, 1'b1, 1'b1);
        drive({8'h10, 8'h00, 8'h00}, '0, 3);
        drive({8'h80, 8'h00, 8'h00}, '0, 2);
        cnt(0, 32'd3, "two col clockwise_even_combined");
        cnt(1, 32'd2, "two col ccw odd");
        bus(1'b0, 6'h00, 32'h0, q);
        chk("cfg0 readback", 32'h00c0_0140, q);
    endtask : t_two_col

    // No count when disabled or on a foreign code
    task automatic t_gate;
        logic [31:0] q;
        cfg(0, `RSUC_EV_ADDR_RING, 8'hff, 1'b0, 1'b0);
        cfg(1, 8'h41, 8'hff, 1'b1, 1'b0);
        cfg(2, 8'h3d, 8'hff, 1'b1, 1'b0);
        drive({8'h01, 8'h01, 8'h01}, '0, 4);
        cnt(0, 32'd0, "disabled");
        cnt(1, 32'd0, "code 41");
        cnt(2, 32'd0, "code 3d");
        bus(1'b0, 6'h30, 32'h0, q);
        chk("status", 32'h0000_0090, q);
    endtask : t_gate

    task automatic final_report;
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_codes();
        t_mask_bits();
        t_dir();
        t_two_col();
        t_gate();
        final_report();
    end

    // Run needs about 650 cycles
    initial begin
        repeat (20000) @(posedge core_clk_i);
        bad_count++;
        final_report();
    end
endmodule : ring_stop_usage_event_counter_tb

`default_nettype wire

/* tb/rsuc_ring_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Ring traffic seen at the stop
// ----------------------------------------
module rsuc_ring_model (
    // Clock
    input  wire logic            core_clk_i,
    // Bench request
    input  wire logic            go_i,
    input  wire logic [2:0][7:0] vld_req_i,
    input  wire logic [2:0][7:0] inj_req_i,
    // Ring observation
    output var  logic [2:0][7:0] vld_o,
    output var  logic [2:0][7:0] inj_o
);
    // Lowest set bit: one packet per direction at most
    function automatic logic [7:0] first_one(input logic [7:0] v);
        return v & (~v + 8'h01);
    endfunction : first_one

    always_ff @(posedge core_clk_i) begin
        for (int r = 0; r < 3; r++) begin
            vld_o[r] <= go_i ? (first_one(vld_req_i[r] & 8'h33) |
                                first_one(vld_req_i[r] & 8'hcc)) : 8'h00;
            inj_o[r] <= go_i ? inj_req_i[r] : 8'h00;
        end
    end
endmodule : rsuc_ring_model

`default_nettype wire
